// >>> dv/dtc_dual_timer_counter_tb.sv
// Self-checking bench for the dual timer/counter.
// Assumes the register port contract: read data stands one cycle later.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module dual_timer_counter_tb
  import dtc_pkg::*;
;
  logic       i_clk;
  logic       i_rst;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  wire  [1:0] count_pin;
  wire  [1:0] int_pin_n;
  logic [1:0] o_pin_out;
  logic [1:0] o_pin_oe;
  logic [1:0] o_timer_irq;
  logic [1:0] o_ext_irq;
  int         mismatches;
  int         total_checks;
  logic [7:0] d;
  logic       hit;
  int         f;
  int         p;
  int         t;

  dtc_dual_timer_counter u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_count_pin(count_pin),
    .i_ext_int_pin_n(int_pin_n), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_timer_irq(o_timer_irq),
    .o_ext_irq(o_ext_irq));
  dtc_pin_model u_model (.i_clk(i_clk), .o_count_pin(count_pin),
    .o_ext_int_pin_n(int_pin_n));

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Stops at the first flag seen so the count has barely moved past wrap
  task automatic wait_flag(input int idx, output logic h);
    h = 1'b0;
    for (int k = 0; k < 12 && h !== 1'b1; k++)
    begin
      idle(1);
      h = (o_timer_irq[idx] === 1'b1);
    end
  endtask

  task automatic sample(input int n, output int fc, output int pc,
                        output int tc);
    logic prev;
    fc = 0;
    pc = 0;
    tc = 0;
    prev = o_pin_out[1];
    repeat (n)
    begin
      idle(1);
      fc += (o_timer_irq[0] === 1'b1);
      pc += (o_pin_out[0] === 1'b1);
      tc += (o_pin_out[1] !== prev);
      prev = o_pin_out[1];
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole sequence needs about 2100 cycles
  initial
  begin
    #(20 * 20000);
    mismatches++;
    final_report();
  end

  initial
  begin
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(DTC_ADDR_CTRL, d);
    `CHK("ctrl_reset", DTC_CTRL_RST, d)
    wr(8'h90, 8'hFF);
    rd(8'h90, d);
    `CHK("unmapped", 8'h00, d)
    $display("test reset done");
    wr(DTC_ADDR_HIGH0, 8'hFF);
    wr(DTC_ADDR_LOW0, 8'h1E);
    wr(DTC_ADDR_CTRL, 8'h10);
    wait_flag(0, hit);
    `CHK("m0_flag", 1'b1, hit)
    wr(DTC_ADDR_CTRL, 8'h00);
    rd(DTC_ADDR_HIGH0, d);
    `CHK("m0_high", 8'h00, d)
    wr(DTC_ADDR_HIGH0, 8'hFF);
    wr(DTC_ADDR_LOW0, 8'hFE);
    wr(DTC_ADDR_MODE, 8'h01);
    wr(DTC_ADDR_CTRL, 8'h10);
    wait_flag(0, hit);
    `CHK("m1_flag", 1'b1, hit)
    wr(DTC_ADDR_ACK, 8'h02);
    idle(1);
    `CHK("m1_ack", 1'b0, o_timer_irq[0])
    wr(DTC_ADDR_CTRL, 8'h00);
    rd(DTC_ADDR_HIGH0, d);
    `CHK("m1_high", 8'h00, d)
    $display("test wide done");
    wr(DTC_ADDR_HIGH1, 8'hF0);
    wr(DTC_ADDR_LOW1, 8'hFE);
    wr(DTC_ADDR_MODE, 8'h20);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_flag(1, hit);
    `CHK("m2_flag", 1'b1, hit)
    wr(DTC_ADDR_CTRL, 8'h00);
    rd(DTC_ADDR_LOW1, d);
    `CHK("m2_reload", 1'b1, d >= 8'hF0)
    rd(DTC_ADDR_HIGH1, d);
    `CHK("m2_high", 8'hF0, d)
    $display("test reload done");
    wr(DTC_ADDR_MODE, 8'h09);
    wr(DTC_ADDR_LOW0, 8'h55);
    u_model.set_int(0, 1'b0);
    wr(DTC_ADDR_CTRL, 8'h10);
    idle(10);
    `CHK("level_low", 1'b1, o_ext_irq[0])
    rd(DTC_ADDR_LOW0, d);
    `CHK("gate_shut", 8'h55, d)
    u_model.set_int(0, 1'b1);
    idle(10);
    `CHK("level_high", 1'b0, o_ext_irq[0])
    rd(DTC_ADDR_LOW0, d);
    `CHK("gate_open", 1'b1, d !== 8'h55)
    wr(DTC_ADDR_CTRL, 8'h04);
    u_model.set_int(1, 1'b0);
    idle(5);
    u_model.set_int(1, 1'b1);
    idle(5);
    `CHK("edge_irq", 1'b1, o_ext_irq[1])
    rd(DTC_ADDR_CTRL, d);
    `CHK("edge_bit", 1'b1, d[DTC_IE1])
    wr(DTC_ADDR_ACK, 8'h04);
    idle(1);
    `CHK("edge_ack", 1'b0, o_ext_irq[1])
    $display("test gate done");
    wr(DTC_ADDR_CTRL, 8'h00);
    wr(DTC_ADDR_MODE, 8'h05);
    wr(DTC_ADDR_LOW0, 8'h00);
    wr(DTC_ADDR_HIGH0, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h10);
    u_model.pulse(0, 5);
    idle(5);
    wr(DTC_ADDR_CTRL, 8'h00);
    rd(DTC_ADDR_LOW0, d);
    `CHK("events", 8'h05, d)
    $display("test counter done");
    wr(DTC_ADDR_MODE, 8'h03);
    wr(DTC_ADDR_HIGH0, 8'hFE);
    wr(DTC_ADDR_CTRL, 8'h40);
    wait_flag(1, hit);
    `CHK("split_high", 1'b1, hit)
    `CHK("split_t0", 1'b0, o_timer_irq[0])
    wr(DTC_ADDR_MODE, 8'h33);
    wr(DTC_ADDR_LOW1, 8'h77);
    idle(20);
    rd(DTC_ADDR_LOW1, d);
    `CHK("t1_parked", 8'h77, d)
    wr(DTC_ADDR_MODE, 8'h13);
    idle(20);
    rd(DTC_ADDR_LOW1, d);
    `CHK("t1_resumed", 1'b1, d !== 8'h77)
    wr(DTC_ADDR_CTRL, 8'h00);
    wr(DTC_ADDR_LOW0, 8'hFE);
    wr(DTC_ADDR_CTRL, 8'h10);
    wait_flag(0, hit);
    `CHK("split_low", 1'b1, hit)
    $display("test split done");
    wr(DTC_ADDR_CTRL, 8'h00);
    wr(DTC_ADDR_MODE, 8'h02);
    wr(DTC_ADDR_MODEX, 8'h01);
    wr(DTC_ADDR_HIGH0, 8'h40);
    wr(DTC_ADDR_CTRL, 8'h10);
    idle(300);
    sample(256, f, p, t);
    `CHK("pwm_flag", 192, f)
    `CHK("pwm_pin", 192, p)
    `CHK("pwm_oe", 1'b1, o_pin_oe[0])
    t = 0;
    while (o_timer_irq[0] !== 1'b1 && t < 300)
    begin
      idle(1);
      t++;
    end
    `CHK("pwm_rise", 1'b1, o_timer_irq[0])
    wr(DTC_ADDR_CTRL, 8'h10);
    idle(1);
    `CHK("pwm_sw_clr", 1'b0, o_timer_irq[0])
    wr(DTC_ADDR_HIGH0, DTC_PWM_LO);
    idle(300);
    sample(256, f, p, t);
    `CHK("pwm_00", 256, p)
    wr(DTC_ADDR_HIGH0, DTC_PWM_HI);
    idle(300);
    sample(256, f, p, t);
    `CHK("pwm_ff", 0, p)
    `CHK("pwm_ff_flag", 0, f)
    wr(DTC_ADDR_CTRL, 8'h00);
    wr(DTC_ADDR_MODEX, 8'h00);
    $display("test pwm done");
    wr(DTC_ADDR_MODE, 8'h20);
    wr(DTC_ADDR_HIGH1, 8'hF0);
    wr(DTC_ADDR_LOW1, 8'hF0);
    wr(DTC_ADDR_AUX, 8'h02);
    idle(1);
    `CHK("tog_start", 1'b1, o_pin_out[1])
    `CHK("tog_oe", 1'b1, o_pin_oe[1])
    wr(DTC_ADDR_CTRL, 8'h40);
    idle(5);
    sample(160, f, p, t);
    `CHK("tog_count", 10, t)
    $display("test toggle done");
    final_report();
  end
endmodule
`default_nettype wire

// >>> dv/dtc_pin_model.sv
// Pin-side partner of the dual timer/counter: count and interrupt pins.
// Assumes the bench clock; pins idle high and change after an edge.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model
(
  // Clock
  input  wire logic       i_clk,
  // Pins toward the design
  output logic      [1:0] o_count_pin,
  output logic      [1:0] o_ext_int_pin_n
);
  initial
  begin
    o_count_pin     = 2'h3;
    o_ext_int_pin_n = 2'h3;
  end

  // Each level is held at least 3 cycles so the 2-flop synchroniser cannot miss it
  task pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_count_pin[idx] <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_count_pin[idx] <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
  endtask

  task set_int(input int idx, input logic v);
    @(posedge i_clk);
    o_ext_int_pin_n[idx] <= v;
  endtask
endmodule
`default_nettype wire

// >>> rtl/dtc_dual_timer_counter.sv
// Two timer/counters with shared control/status, modes 0,1,2,3,6,
// external interrupt flags and overflow toggle outputs.
// Assumes a simple register port (read data one cycle later) and
// asynchronous pins that are synchronised here.
// Contract
// - Mode 0: 13-bit count, high byte plus low five bits prescaler
// - Wrap from all ones to zero sets that timer's overflow flag
// - Count only when run bit set and gate clear or pin high
// - Setting run bit leaves count bytes unchanged
// - Mode 1: full 16-bit count, no prescaler
// - Mode 2: low byte counts, reloads from high byte on overflow
// - Timer 1 in mode 3 is stopped, like run bit cleared
// - Timer 0 mode 3: low byte is 8-bit timer with timer 0 controls
// - Timer 0 mode 3: high byte counts clocks, uses timer 1 run/flag
// - Timer 1 starts/stops via own mode 3 while timer 0 split
// - Mode 6: PWM with period 256 timer clocks, reload-like
// - Mode 6: flag low for high-byte clocks, high for rest
// - Mode 6: 00h forces pin high, FFh forces pin low
// - Mode 6: hardware sets and clears flag as waveform
// - Mode 6: rising flag still interrupts; software may clear
// - Flags bits 5,7 set on overflow; cleared by vector or software
// - Type bits 0,2: set edge triggered, clear level triggered
// - Edge flags bits 1,3 set on edge; cleared by ack or software
// - Toggle enable inverts the count pin on each overflow
// - Pin driven 1 after toggle enabled until first overflow
// - Mode codes 000,001,010,011,110; others reserved
// - Select clear counts core clock, set counts pin events
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dtc_dual_timer_counter
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Pins: count inputs, external interrupt inputs (active low)
  input  wire logic [1:0] i_count_pin,
  input  wire logic [1:0] i_ext_int_pin_n,
  // Pin outputs: toggle/PWM drive
  output logic      [1:0] o_pin_out,
  output logic      [1:0] o_pin_oe,
  // Interrupt requests to the core
  output logic      [1:0] o_timer_irq,
  output logic      [1:0] o_ext_irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [1:0] modex0;
    logic [1:0] ent;
    logic [7:0] low0;
    logic [7:0] low1;
    logic [7:0] high0;
    logic [7:0] high1;
    logic [1:0] cnt_s1;
    logic [1:0] cnt_s2;
    logic [1:0] cnt_old;
    logic [1:0] int_s1;
    logic [1:0] int_s2;
    logic [1:0] int_old;
    logic [1:0] pin;
    logic [1:0] pwm_old;
    logic [7:0] rdata;
  } dtc_state_t;

  dtc_state_t s_reg;
  dtc_state_t s_next;

  logic [2:0] mode0;
  logic [2:0] mode1;
  logic [1:0] tick;
  logic [1:0] run_ok;
  logic [1:0] ext_hi;
  logic [1:0] ovf;
  logic [1:0] tf_set;
  logic       split;
  logic       pwm0;
  logic       pwm1;
  logic [7:0] wr_low0;
  logic [7:0] wr_low1;
  logic [7:0] wr_high0;
  logic [7:0] wr_high1;
  logic [1:0] ent_rise;
  logic [1:0] wave;
  logic       pwm0_nx;
  logic       pwm1_nx;

  assign mode0 = {s_reg.modex0[0], s_reg.mode[1:0]};
  assign mode1 = {s_reg.modex0[1],
                  s_reg.mode[DTC_MODE_T1_LSB+1:DTC_MODE_T1_LSB]};
  assign split = (mode0 == DTC_M_SPLIT);
  assign pwm0  = (mode0 == DTC_M_PWM);
  assign pwm1  = (mode1 == DTC_M_PWM);
  // Synced copy is inverted; the gate wants the pin's own high level
  assign ext_hi = ~s_reg.int_s2;

  // Per-timer count source and enable
  for (genvar n = 0; n < 2; n++)
  begin : g_src
    logic sel;
    logic gate;
    logic fall;
    assign sel  = s_reg.mode[4*n + DTC_SEL_BIT];
    assign gate = s_reg.mode[4*n + DTC_GATE_BIT];
    // Falling edge seen on the second sync stage only
    assign fall = s_reg.cnt_old[n] & ~s_reg.cnt_s2[n];
    assign tick[n] = sel ? fall : 1'b1;
    assign run_ok[n] = s_reg.ctrl[4 + 2*n]
                       & (~gate | ext_hi[n]);
  end

  always_comb
  begin
    s_next   = s_reg;
    ovf      = 2'b00;
    tf_set   = 2'b00;
    ent_rise = 2'b00;

    // Synchronisers and edge history
    s_next.cnt_s1  = i_count_pin;
    s_next.cnt_s2  = s_reg.cnt_s1;
    s_next.cnt_old = s_reg.cnt_s2;
    s_next.int_s1  = ~i_ext_int_pin_n;
    s_next.int_s2  = s_reg.int_s1;
    s_next.int_old = s_reg.int_s2;

    // Software writes land first; hardware counting then overrides
    wr_low0  = s_reg.low0;
    wr_low1  = s_reg.low1;
    wr_high0 = s_reg.high0;
    wr_high1 = s_reg.high1;
    if (i_wr)
    begin
      case (i_addr)
        DTC_ADDR_CTRL:  s_next.ctrl = i_wdata;
        DTC_ADDR_MODE:  s_next.mode = i_wdata;
        DTC_ADDR_MODEX:
          s_next.modex0 = {i_wdata[DTC_MX_T1], i_wdata[DTC_MX_T0]};
        DTC_ADDR_AUX:
        begin
          s_next.ent = {i_wdata[DTC_TOGGLE_OUT_ENABLE_1], i_wdata[DTC_TOGGLE_OUT_ENABLE_0]};
          ent_rise = s_next.ent & ~s_reg.ent;
        end
        DTC_ADDR_LOW0:  wr_low0  = i_wdata;
        DTC_ADDR_LOW1:  wr_low1  = i_wdata;
        DTC_ADDR_HIGH0: wr_high0 = i_wdata;
        DTC_ADDR_HIGH1: wr_high1 = i_wdata;
        DTC_ADDR_ACK:
        begin
          if (i_wdata[DTC_ACK_EX0]) s_next.ctrl[DTC_IE0] = 1'b0;
          if (i_wdata[DTC_ACK_EX1]) s_next.ctrl[DTC_IE1] = 1'b0;
          if (i_wdata[DTC_ACK_T0] && !pwm0)
            s_next.ctrl[DTC_TF0] = 1'b0;
          if (i_wdata[DTC_ACK_T1] && !pwm1)
            s_next.ctrl[DTC_TF1] = 1'b0;
        end
        default: ;
      endcase
    end
    // Run bit writes never touch counts
    s_next.low0  = wr_low0;
    s_next.low1  = wr_low1;
    s_next.high0 = wr_high0;
    s_next.high1 = wr_high1;

    // Timer 0
    if (run_ok[0] && tick[0])
    begin
      case (mode0)
        DTC_M_PRE13:
        begin
          s_next.low0 = {3'h0, wr_low0[4:0] + 5'h01};
          if (wr_low0[4:0] == DTC_PRE_MAX[4:0])
          begin
            s_next.high0 = wr_high0 + 8'h01;
            ovf[0] = (wr_high0 == 8'hFF);
          end
        end
        DTC_M_FULL16:
        begin
          {s_next.high0, s_next.low0} = {wr_high0, wr_low0} + 16'h0001;
          ovf[0] = ({wr_high0, wr_low0} == 16'hFFFF);
        end
        DTC_M_RELOAD:
        begin
          ovf[0] = (wr_low0 == 8'hFF);
          s_next.low0 = ovf[0] ? wr_high0 : wr_low0 + 8'h01;
        end
        // No reload here: the period must stay 256 whatever the duty
        DTC_M_PWM:
        begin
          ovf[0] = (wr_low0 == 8'hFF);
          s_next.low0 = wr_low0 + 8'h01;
        end
        DTC_M_SPLIT:
        begin
          ovf[0] = (wr_low0 == 8'hFF);
          s_next.low0 = wr_low0 + 8'h01;
        end
        default: ;
      endcase
    end
    // Split high byte counts core clocks under the second run bit
    if (split && s_reg.ctrl[DTC_TR1])
    begin
      s_next.high0 = wr_high0 + 8'h01;
      tf_set[1] = (wr_high0 == 8'hFF);
    end

    // Timer 1: mode 3 stops it; still runs while timer 0 is split
    if (run_ok[1] && tick[1] && mode1 != DTC_M_SPLIT)
    begin
      case (mode1)
        DTC_M_PRE13:
        begin
          s_next.low1 = {3'h0, wr_low1[4:0] + 5'h01};
          if (wr_low1[4:0] == DTC_PRE_MAX[4:0])
          begin
            s_next.high1 = wr_high1 + 8'h01;
            ovf[1] = (wr_high1 == 8'hFF);
          end
        end
        DTC_M_FULL16:
        begin
          {s_next.high1, s_next.low1} = {wr_high1, wr_low1} + 16'h0001;
          ovf[1] = ({wr_high1, wr_low1} == 16'hFFFF);
        end
        DTC_M_RELOAD:
        begin
          ovf[1] = (wr_low1 == 8'hFF);
          s_next.low1 = ovf[1] ? wr_high1 : wr_low1 + 8'h01;
        end
        DTC_M_PWM:
        begin
          ovf[1] = (wr_low1 == 8'hFF);
          s_next.low1 = wr_low1 + 8'h01;
        end
        default: ;
      endcase
    end

    // Overflow flags; split mode steals timer 1's flag
    tf_set[0] = ovf[0] & ~pwm0;
    if (!split)
      tf_set[1] = ovf[1] & ~pwm1;
    if (tf_set[0]) s_next.ctrl[DTC_TF0] = 1'b1;
    if (tf_set[1]) s_next.ctrl[DTC_TF1] = 1'b1;
    // PWM wave: low while low byte below high byte, high for the rest; held low whenever high byte is FFh
    wave[0] = (s_next.low0 >= s_next.high0)
              && (s_next.high0 != DTC_PWM_HI);
    wave[1] = (s_next.low1 >= s_next.high1)
              && (s_next.high1 != DTC_PWM_HI);
    // Flag moves only on wave edges, so a software clear holds till
    // the next rise; a rise in the same cycle as the clear wins
    if (pwm0 && wave[0] != s_reg.pwm_old[0])
      s_next.ctrl[DTC_TF0] = wave[0];
    if (pwm1 && wave[1] != s_reg.pwm_old[1])
      s_next.ctrl[DTC_TF1] = wave[1];
    s_next.pwm_old = wave;

    // External interrupt flags: edge mode latches falling pins
    if (s_reg.ctrl[DTC_IT0])
    begin
      if (s_reg.int_s2[0] & ~s_reg.int_old[0])
        s_next.ctrl[DTC_IE0] = 1'b1;
    end
    else
      s_next.ctrl[DTC_IE0] = s_reg.int_s2[0];
    if (s_reg.ctrl[DTC_IT1])
    begin
      if (s_reg.int_s2[1] & ~s_reg.int_old[1])
        s_next.ctrl[DTC_IE1] = 1'b1;
    end
    else
      s_next.ctrl[DTC_IE1] = s_reg.int_s2[1];

    // Toggle and PWM pin drive
    for (int n = 0; n < 2; n++)
    begin
      if (ent_rise[n])
        s_next.pin[n] = 1'b1;
      else if (s_next.ent[n] && ovf[n])
        s_next.pin[n] = ~s_reg.pin[n];
    end
    // Decode the mode being entered so the pin never lags a mode write
    pwm0_nx = ({s_next.modex0[0], s_next.mode[1:0]} == DTC_M_PWM);
    pwm1_nx = ({s_next.modex0[1],
                s_next.mode[DTC_MODE_T1_LSB+1:DTC_MODE_T1_LSB]}
               == DTC_M_PWM);
    if (pwm0_nx)
      s_next.pin[0] = (s_next.high0 == DTC_PWM_LO) ? 1'b1 :
                      wave[0];
    if (pwm1_nx)
      s_next.pin[1] = (s_next.high1 == DTC_PWM_LO) ? 1'b1 :
                      wave[1];

    // Read data stands one cycle after the strobe
    s_next.rdata = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        DTC_ADDR_CTRL:  s_next.rdata = s_reg.ctrl;
        DTC_ADDR_MODE:  s_next.rdata = s_reg.mode;
        DTC_ADDR_MODEX: s_next.rdata = {3'h0, s_reg.modex0[1], 3'h0,
                                        s_reg.modex0[0]};
        DTC_ADDR_AUX:   s_next.rdata = {6'h00, s_reg.ent};
        DTC_ADDR_LOW0:  s_next.rdata = s_reg.low0;
        DTC_ADDR_LOW1:  s_next.rdata = s_reg.low1;
        DTC_ADDR_HIGH0: s_next.rdata = s_reg.high0;
        DTC_ADDR_HIGH1: s_next.rdata = s_reg.high1;
        default:        s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg        <= '0;
      s_reg.ctrl   <= DTC_CTRL_RST;
      s_reg.mode   <= DTC_MODE_RST;
      s_reg.low0   <= DTC_BYTE_RST;
      s_reg.low1   <= DTC_BYTE_RST;
      s_reg.high0  <= DTC_BYTE_RST;
      s_reg.high1  <= DTC_BYTE_RST;
      s_reg.pin    <= DTC_PIN_RST;
    end
    else
      s_reg <= s_next;
  end

  assign o_rdata     = s_reg.rdata;
  assign o_pin_out   = s_reg.pin;
  assign o_pin_oe    = s_reg.ent | {pwm1, pwm0};
  assign o_timer_irq = {s_reg.ctrl[DTC_TF1], s_reg.ctrl[DTC_TF0]};
  assign o_ext_irq   = {s_reg.ctrl[DTC_IE1], s_reg.ctrl[DTC_IE0]};

  // Assertions
  a_run_hold_bytes: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (!s_reg.ctrl[DTC_TR0] && !i_wr && !split && mode0 != DTC_M_PWM)
    |=> $stable(s_reg.low0)) else $error("timer0 moved while stopped");
  a_wrap_sets_flag: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (ovf[0] && !pwm0) |=> s_reg.ctrl[DTC_TF0])
    else $error("overflow flag not set");
  a_t1_split_stop: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (mode1 == DTC_M_SPLIT && !i_wr) |=> $stable(s_reg.low1))
    else $error("timer1 counted in mode 3");
  a_reload_value: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (ovf[0] && mode0 == DTC_M_RELOAD && !i_wr)
    |=> s_reg.low0 == $past(s_reg.high0))
    else $error("reload wrong");
  a_reload_t1: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (ovf[1] && mode1 == DTC_M_RELOAD && !i_wr)
    |=> s_reg.low1 == $past(s_reg.high1))
    else $error("timer1 reload wrong");
  a_split_hi_cnt: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (split && s_reg.ctrl[DTC_TR1] && !i_wr)
    |=> s_reg.high0 == $past(s_reg.high0) + 8'h01)
    else $error("split high byte stalled");
  a_pwm_force_lo: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (pwm0 && s_reg.high0 == DTC_PWM_HI && $stable(s_reg.high0))
    |-> !s_reg.pin[0]) else $error("pwm FFh pin not low");
  a_toggle_start: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ent_rise[0] && !pwm0 |=> s_reg.pin[0])
    else $error("toggle pin not high at enable");
  a_edge_flag_set: assert property (@(posedge i_clk)
    disable iff (i_rst)
    (s_reg.ctrl[DTC_IT0] && s_reg.int_s2[0] && !s_reg.int_old[0])
    |=> s_reg.ctrl[DTC_IE0]) else $error("edge flag missed");

endmodule
`default_nettype wire

// >>> rtl/dtc_pkg.sv
// Package for the dual timer/counter: register offsets, field positions,
// reset values and mode codes. Shared by the design and its bench.
`default_nettype none
package dtc_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] DTC_ADDR_CTRL    = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE    = 8'h89;
  localparam logic [7:0] DTC_ADDR_LOW0    = 8'h8A;
  localparam logic [7:0] DTC_ADDR_LOW1    = 8'h8B;
  localparam logic [7:0] DTC_ADDR_HIGH0   = 8'h8C;
  localparam logic [7:0] DTC_ADDR_HIGH1   = 8'h8D;
  localparam logic [7:0] DTC_ADDR_MODEX   = 8'h8F;
  localparam logic [7:0] DTC_ADDR_AUX     = 8'hA2;
  localparam logic [7:0] DTC_ADDR_ACK     = 8'hA3;

  // Control/status register fields
  localparam int DTC_IT0 = 0;
  localparam int DTC_IE0 = 1;
  localparam int DTC_IT1 = 2;
  localparam int DTC_IE1 = 3;
  localparam int DTC_TR0 = 4;
  localparam int DTC_TF0 = 5;
  localparam int DTC_TR1 = 6;
  localparam int DTC_TF1 = 7;

  // Mode register fields (per timer nibble: mode bits 0..1, select, gate)
  localparam int DTC_MODE_T1_LSB = 4;
  localparam int DTC_SEL_BIT     = 2;
  localparam int DTC_GATE_BIT    = 3;
  // Extended mode register: top mode bit of each timer
  localparam int DTC_MX_T0 = 0;
  localparam int DTC_MX_T1 = 4;
  // Auxiliary register: toggle output enables
  localparam int DTC_TOGGLE_OUT_ENABLE_0 = 0;
  localparam int DTC_TOGGLE_OUT_ENABLE_1 = 1;
  // Acknowledge register: one bit per vectored interrupt
  localparam int DTC_ACK_EX0 = 0;
  localparam int DTC_ACK_T0  = 1;
  localparam int DTC_ACK_EX1 = 2;
  localparam int DTC_ACK_T1  = 3;

  localparam logic [7:0] DTC_CTRL_RST = 8'h00;
  localparam logic [7:0] DTC_MODE_RST = 8'h00;
  localparam logic [7:0] DTC_BYTE_RST = 8'h00;
  localparam logic [7:0] DTC_PRE_MAX  = 8'h1F;
  localparam logic [7:0] DTC_PWM_HI   = 8'hFF;
  localparam logic [7:0] DTC_PWM_LO   = 8'h00;
  localparam logic [1:0] DTC_PIN_RST  = 2'h3;

  // Mode field codes
  localparam logic [2:0] DTC_M_PRE13  = 3'h0;
  localparam logic [2:0] DTC_M_FULL16 = 3'h1;
  localparam logic [2:0] DTC_M_RELOAD = 3'h2;
  localparam logic [2:0] DTC_M_SPLIT  = 3'h3;
  localparam logic [2:0] DTC_M_PWM    = 3'h6;

endpackage
`default_nettype wire
